// [hdl/pti_master.sv]
`timescale 1ns/1ps
// master end: one transfer of up to 15 words per request
module pti_master (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // bus
   pti_bus_if.master bus,
   // request
   input wire logic req_i,
   input wire logic [3:0] cmd_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] be_n_i,
   input wire logic [3:0] len_i,
   input wire logic idsel_i,
   // answer
   output logic busy_o,
   output logic [31:0] rdata_o,
   output logic rvalid_o,
   output logic done_o,
   output logic abort_o,
   output logic irq_o
);
   typedef enum logic [2:0] {
      MS_IDLE, MS_ADDR, MS_DATA, MS_TURN
   } pti_mst_t;

   pti_mst_t st_r;             // master state
   logic [3:0] left_r;         // words still to move
   logic [3:0] cmd_r;          // held command
   logic [3:0] dsel_cnt_r;     // cycles waited for devsel
   logic ap_par_r;             // address parity pending
   logic wpar_r;               // write parity pending
   logic [31:0] ad_r;          // driven address or data
   logic [3:0] cbe_r;          // driven command or enables
   logic is_rd;
   logic int_s1_r, int_s2_r; // interrupt line synchroniser
   logic xfer;

   // interrupt line may change at any time: two flops before use
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_s1_r <= 1'b1;
         int_s2_r <= 1'b1;
      end else begin
         int_s1_r <= bus.inta_n;
         int_s2_r <= int_s1_r;
      end
   end

   assign is_rd = !cmd_r[0];
   // same clock as the target, so its lines are read directly;
   // a synchroniser here would miss the one-cycle ready
   assign xfer = (st_r == MS_DATA) && !bus.trdy_n;

   // transaction sequencing
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= MS_IDLE;
         left_r <= 4'h0;
         cmd_r <= 4'h0;
         dsel_cnt_r <= 4'h0;
         rdata_o <= 32'h0;
         rvalid_o <= 1'b0;
         done_o <= 1'b0;
         abort_o <= 1'b0;
      end else begin
         rvalid_o <= 1'b0;
         done_o <= 1'b0;
         abort_o <= 1'b0;
         case (st_r)
            MS_IDLE: if (req_i) begin
               cmd_r <= cmd_i;
               left_r <= (len_i == 4'h0) ? 4'h1 : len_i;
               dsel_cnt_r <= 4'h0;
               st_r <= MS_ADDR;
            end
            MS_ADDR: st_r <= MS_DATA;
            MS_DATA: begin
               dsel_cnt_r <= dsel_cnt_r + 4'h1;
               if (xfer) begin
                  if (is_rd) begin
                     rdata_o <= bus.ad;
                     rvalid_o <= 1'b1;
                  end
                  left_r <= left_r - 4'h1;
                  if (left_r == 4'h1 || !bus.stop_n) begin
                     done_o <= 1'b1;
                     st_r <= MS_TURN;
                  end
               end else if (!bus.stop_n) begin
                  // disconnect without data: end with the target
                  done_o <= 1'b1;
                  st_r <= MS_TURN;
               end else if (bus.devsel_n && dsel_cnt_r == 4'hF) begin
                  abort_o <= 1'b1; // nobody claimed
                  st_r <= MS_TURN;
               end
            end
            MS_TURN: st_r <= MS_IDLE;
            default: st_r <= MS_IDLE;
         endcase
      end
   end

   // lines driven in address and data phases
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ad_r <= 32'h0;
         cbe_r <= 4'hF;
         ap_par_r <= 1'b0;
         wpar_r <= 1'b0;
         bus.m_par_o <= 1'b0;
      end else begin
         if (st_r == MS_IDLE && req_i) begin
            ad_r <= addr_i;
            cbe_r <= cmd_i;
         end else if (st_r == MS_ADDR) begin
            ad_r <= wdata_i;
            cbe_r <= be_n_i;
         end
         // parity one clock after address and after write data
         ap_par_r <= (st_r == MS_ADDR);
         wpar_r <= (st_r == MS_DATA) && !is_rd;
         bus.m_par_o <= pti_pkg::par36(ad_r, cbe_r);
      end
   end

   assign bus.m_ad_o = ad_r;
   assign bus.cbe_n = cbe_r;
   assign bus.m_ad_oe_n = !(st_r == MS_ADDR || (st_r == MS_DATA && !is_rd));
   assign bus.m_par_oe_n = !(ap_par_r || wpar_r);
   // frame drops for the last word or as soon as stop is seen
   assign bus.frame_n = !(st_r == MS_ADDR ||
                          (st_r == MS_DATA && left_r > 4'h1 && bus.stop_n));
   assign bus.irdy_n = (st_r != MS_DATA);
   assign bus.idsel = idsel_i && (st_r == MS_ADDR);
   assign busy_o = (st_r != MS_IDLE);
   assign irq_o = !int_s2_r;
endmodule : pti_master

// [hdl/pti_target.sv]
`timescale 1ns/1ps
module pti_target (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // bus
   pti_bus_if.target bus,
   // user side
   input wire logic [31:0] base_i,
   input wire logic irq_req_i,
   output logic [31:0] cfg_word_o,
   output logic wr_pulse_o
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEC, ST_DATA, ST_TURN, ST_SKIP
   } pti_st_t;

   pti_st_t st_r;                    // phase tracker
   logic [31:0] addr_r;              // latched address
   logic [3:0] cmd_r;                // latched command
   logic idsel_r;                    // latched chip select
   logic [31:0] mem_r [pti_pkg::WORDS]; // local word store
   logic [31:0] cfg_r;               // configuration word
   logic [3:0] beat_r;               // words moved in this burst
   logic [1:0] wait_r;               // read wait counter
   logic rd_valid_r;                 // read data now on the lines
   logic trdy_r, stop_r;             // ready and disconnect, active high
   logic par_en_r;                   // parity drive next cycle
   logic irq_s1_r, irq_s2_r;         // synchroniser for request input

   logic claim, is_rd, is_cfg, done;
   logic [pti_pkg::WIDX_W-1:0] widx;

   // decode after latching; commands outside the set are ignored
   always_comb begin
      is_cfg = (cmd_r == pti_pkg::CMD_CFG_RD) ||
               (cmd_r == pti_pkg::CMD_CFG_WR);
      is_rd = (cmd_r == pti_pkg::CMD_IO_RD) ||
              (cmd_r == pti_pkg::CMD_MEM_RD) ||
              (cmd_r == pti_pkg::CMD_CFG_RD);
      claim = 1'b0;
      if (is_cfg) begin
         claim = idsel_r;
      end else if (cmd_r == pti_pkg::CMD_IO_RD ||
                   cmd_r == pti_pkg::CMD_IO_WR ||
                   cmd_r == pti_pkg::CMD_MEM_RD ||
                   cmd_r == pti_pkg::CMD_MEM_WR) begin
         claim = (addr_r[31:pti_pkg::DEC_LSB] ==
                  base_i[31:pti_pkg::DEC_LSB]);
      end
   end

   // data phase completes when both readies are low on the wire
   assign done = (st_r == ST_DATA) && !bus.irdy_n && trdy_r;
   // burst word follows the start word; beat count widened to the index
   assign widx = addr_r[pti_pkg::WIDX_W+1:2] +
                 {{(pti_pkg::WIDX_W-4){1'b0}}, beat_r};

   // phase tracker; everything clocked from the bus clock
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= ST_IDLE;
         addr_r <= 32'h0;
         cmd_r <= 4'h0;
         idsel_r <= 1'b0;
      end else begin
         case (st_r)
            ST_IDLE: begin
               // address phase: first cycle with frame low
               if (!bus.frame_n) begin
                  addr_r <= bus.ad;
                  cmd_r <= bus.cbe_n;
                  idsel_r <= bus.idsel;
                  st_r <= ST_DEC;
               end
            end
            ST_DEC: begin
               // not ours: watch the transfer go by without driving
               st_r <= claim ? ST_DATA : ST_SKIP;
            end
            ST_DATA: begin
               // frame high at completion marks the final phase
               if ((done && bus.frame_n) ||
                   (stop_r && !bus.irdy_n && bus.frame_n)) begin
                  st_r <= ST_TURN;
               end
            end
            ST_TURN: st_r <= ST_IDLE; // turnaround cycle
            ST_SKIP: begin
               if (bus.frame_n && bus.irdy_n) begin
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // read wait: data goes out before ready, never together with old data
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_r <= 2'h0;
         rd_valid_r <= 1'b0;
         trdy_r <= 1'b0;
         beat_r <= 4'h0;
         stop_r <= 1'b0;
      end else if (st_r != ST_DATA) begin
         wait_r <= 2'h0;
         rd_valid_r <= 1'b0;
         trdy_r <= 1'b0;
         beat_r <= 4'h0;
         stop_r <= 1'b0;
      end else if (done) begin
         // fresh word needed for each read beat
         trdy_r <= 1'b0;
         rd_valid_r <= 1'b0;
         wait_r <= 2'h0;
         beat_r <= beat_r + 4'h1;
         // disconnect once BURST_MAX - 1 words have moved
         stop_r <= (beat_r + 4'h1 >= pti_pkg::BURST_MAX - 4'h1);
      end else if (is_rd) begin
         if (wait_r == pti_pkg::RD_WAIT) begin
            rd_valid_r <= 1'b1;
         end else begin
            wait_r <= wait_r + 2'h1;
         end
         trdy_r <= rd_valid_r && !stop_r;
      end else begin
         // write store always free: accept at once
         trdy_r <= !stop_r;
      end
   end

   // byte-lane merge on writes
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_r <= 32'h0;
         wr_pulse_o <= 1'b0;
      end else begin
         wr_pulse_o <= done && !is_rd;
         if (done && !is_rd && is_cfg) begin
            for (int b = 0; b < 4; b++) begin
               if (!bus.cbe_n[b]) begin
                  cfg_r[b*8 +: 8] <= bus.ad[b*8 +: 8];
               end
            end
         end
      end
   end

   // word store has no reset: a large array is cheaper without one
   always_ff @(posedge core_clk_i) begin
      if (done && !is_rd && !is_cfg) begin
         for (int b = 0; b < 4; b++) begin
            if (!bus.cbe_n[b]) begin
               mem_r[widx][b*8 +: 8] <= bus.ad[b*8 +: 8];
            end
         end
      end
   end

   // output drive and parity one cycle behind
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus.t_ad_o <= 32'h0;
         bus.t_par_o <= 1'b0;
         par_en_r <= 1'b0;
      end else begin
         if (st_r == ST_DATA && is_rd) begin
            bus.t_ad_o <= is_cfg ? cfg_r : mem_r[widx];
         end
         // parity tracks the lines we drove last cycle
         par_en_r <= (st_r == ST_DATA) && is_rd && rd_valid_r;
         bus.t_par_o <= pti_pkg::par36(bus.t_ad_o, bus.cbe_n);
      end
   end

   // interrupt request through two flops; pin only pulled low
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_s1_r <= 1'b0;
         irq_s2_r <= 1'b0;
      end else begin
         irq_s1_r <= irq_req_i;
         irq_s2_r <= irq_s1_r;
      end
   end

   assign bus.t_ad_oe_n = !(st_r == ST_DATA && is_rd && rd_valid_r);
   assign bus.t_par_oe_n = !par_en_r;
   assign bus.ctl_oe_n = !(st_r == ST_DATA || st_r == ST_TURN);
   assign bus.devsel_n_o = (st_r != ST_DATA);
   assign bus.trdy_n_o = !trdy_r;
   // stop only with devsel; released in the turnaround cycle
   assign bus.stop_n_o = !(stop_r && st_r == ST_DATA);
   assign bus.inta_n_oe_n = !irq_s2_r;
   assign cfg_word_o = cfg_r;
endmodule : pti_target

// [inc/pti_bus_if.sv]
`timescale 1ns/1ps
// shared bus: two-way lines appear as in/out/enable per party
interface pti_bus_if;
   // master side drives
   logic [31:0] m_ad_o;
   logic m_ad_oe_n;
   logic [3:0] cbe_n;
   logic frame_n;
   logic irdy_n;
   logic idsel;
   logic m_par_o;
   logic m_par_oe_n;
   logic rst_n;
   // target side drives
   logic [31:0] t_ad_o;
   logic t_ad_oe_n;
   logic trdy_n_o;
   logic devsel_n_o;
   logic stop_n_o;
   logic ctl_oe_n;
   logic t_par_o;
   logic t_par_oe_n;
   logic inta_n_oe_n;
   // resolved wire levels (pull-ups on the control lines; ad and par read zero with no driver)
   logic [31:0] ad;
   logic par;
   logic trdy_n;
   logic devsel_n;
   logic stop_n;
   logic inta_n;
   assign ad = !m_ad_oe_n ? m_ad_o : (!t_ad_oe_n ? t_ad_o : 32'h0);
   assign par = !m_par_oe_n ? m_par_o : (!t_par_oe_n ? t_par_o : 1'b0);
   assign trdy_n = ctl_oe_n ? 1'b1 : trdy_n_o;
   assign devsel_n = ctl_oe_n ? 1'b1 : devsel_n_o;
   assign stop_n = ctl_oe_n ? 1'b1 : stop_n_o;
   assign inta_n = !inta_n_oe_n ? 1'b0 : 1'b1;

   modport target (input ad, cbe_n, frame_n, irdy_n, idsel, rst_n,
                   output t_ad_o, t_ad_oe_n, trdy_n_o, devsel_n_o,
                   stop_n_o, ctl_oe_n, t_par_o, t_par_oe_n, inta_n_oe_n);
   modport master (input ad, par, trdy_n, devsel_n, stop_n, inta_n,
                   output m_ad_o, m_ad_oe_n, cbe_n, frame_n, irdy_n,
                   idsel, m_par_o, m_par_oe_n);
endinterface : pti_bus_if

// [inc/pti_pkg.sv]
package pti_pkg;
   // bus commands carried on the command/byte-enable lines in address phase
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;
   // decode window of the target: upper address bits compared
   localparam int DEC_LSB = 8;
   localparam logic [31:0] BASE_RST = 32'h0000_1000;
   // local word store
   localparam int WORDS = 64;
   localparam int WIDX_W = 6;
   // one more than the words per burst before the target disconnects
   localparam logic [3:0] BURST_MAX = 4'h8;
   // read wait in the target before it drives read data
   localparam logic [1:0] RD_WAIT = 2'h1;

   // even parity over 36 lines, shared by both ends
   function automatic logic par36(input logic [31:0] ad,
                                  input logic [3:0] cbe);
      par36 = ^{ad, cbe};
   endfunction : par36
endpackage : pti_pkg

// [test/pci_target_bus_interface_bench.sv]
`timescale 1ns/1ps
// one compare: counted, a mismatch printed at once
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
   bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
   end end
module pci_target_bus_interface_bench;
   // one request and the outcome it should give
   typedef struct {
      logic [3:0] cmd;
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] be_n;
      logic [3:0] len;
      logic ids;
      logic ok;
   } pti_row_t;
   logic core_clk = 1'b0;
   logic resetn = 1'b1;
   logic req = 1'b0;
   logic irq_req = 1'b0;
   pti_row_t cur = '{4'h0, 32'h0, 32'h0, 4'hF, 4'h0, 1'b0, 1'b0};
   logic busy, rvalid, done, abort, irq, wr_pulse;
   logic [31:0] rdata, cfg_word;
   int bad_count = 0;
   int tests_run = 0;
   int wr_seen; // words written by the last request
   int exp_w; // words a row should write
   logic [31:0] cfg_q = 32'h0; // expected configuration word
   logic got_done, got_abort;
   logic [31:0] mem_q [64]; // expected word store
   pti_row_t rows [11];
   pti_bus_if bus ();
   assign bus.rst_n = resetn;
   pti_target u_pti_target (.core_clk_i(core_clk), .resetn_i(resetn),
      .bus(bus), .base_i(pti_pkg::BASE_RST), .irq_req_i(irq_req),
      .cfg_word_o(cfg_word), .wr_pulse_o(wr_pulse));
   pti_master u_pti_master (.core_clk_i(core_clk), .resetn_i(resetn),
      .bus(bus), .req_i(req), .cmd_i(cur.cmd), .addr_i(cur.addr),
      .wdata_i(cur.data), .be_n_i(cur.be_n), .len_i(cur.len),
      .idsel_i(cur.ids), .busy_o(busy), .rdata_o(rdata), .rvalid_o(rvalid),
      .done_o(done), .abort_o(abort), .irq_o(irq));
   pti_target_asserts #(.BASE(pti_pkg::BASE_RST)) u_pti_target_asserts (
      .core_clk_i(core_clk), .resetn_i(resetn), .ad(bus.ad),
      .cbe_n(bus.cbe_n), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n),
      .idsel(bus.idsel), .par(bus.par), .trdy_n(bus.trdy_n),
      .devsel_n(bus.devsel_n), .stop_n(bus.stop_n),
      .m_ad_oe_n(bus.m_ad_oe_n), .t_ad_oe_n(bus.t_ad_oe_n),
      .t_par_oe_n(bus.t_par_oe_n), .ctl_oe_n(bus.ctl_oe_n));
   // 50 MHz clock
   always #10 core_clk = ~core_clk;
   // verdict and end of run, from tests and watchdog alike
   task automatic end_of_test();
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   // one request; tail cycles catch write pulses after done
   task automatic run(input pti_row_t r);
      logic [31:0] m;
      logic [5:0] rd_w;
      logic [5:0] wr_w;
      int fin;
      logic [31:0] exp_d;
      m = {{8{!r.be_n[3]}}, {8{!r.be_n[2]}}, {8{!r.be_n[1]}}, {8{!r.be_n[0]}}};
      rd_w = r.addr[7:2];
      wr_w = r.addr[7:2];
      fin = 0;
      wr_seen = 0;
      got_done = 1'b0;
      got_abort = 1'b0;
      @(posedge core_clk);
      cur <= r;
      req <= 1'b1;
      @(posedge core_clk);
      req <= 1'b0;
      for (int c = 0; c < 200 && fin < 4; c++) begin
         @(posedge core_clk);
         #1;
         if (fin > 0 || done || abort) fin++;
         if (done) got_done = 1'b1;
         if (abort) got_abort = 1'b1;
         // read beats against the expected store
         if (rvalid) begin
            exp_d = (r.cmd == pti_pkg::CMD_CFG_RD) ? cfg_q : mem_q[rd_w];
            `CHK("rdata", exp_d, rdata)
            rd_w++;
         end
         // written lanes merged by byte enable
         if (wr_pulse) begin
            wr_seen++;
            if (r.cmd == pti_pkg::CMD_CFG_WR) begin
               cfg_q = (cfg_q & ~m) | (r.data & m);
            end else begin
               mem_q[wr_w] = (mem_q[wr_w] & ~m) | (r.data & m);
            end
            wr_w++;
         end
      end
   endtask : run
   // watchdog, far beyond the expected run length
   initial begin
      repeat (6000) @(posedge core_clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      rows = '{
      '{pti_pkg::CMD_MEM_WR, 32'h00001010, 32'hA5A55A5A, 4'h0, 4'h1, 0, 1},
      '{pti_pkg::CMD_MEM_RD, 32'h00001010, 32'h00000000, 4'h0, 4'h1, 0, 1},
      '{pti_pkg::CMD_IO_WR, 32'h00001020, 32'h12345678, 4'h0, 4'h2, 0, 1},
      '{pti_pkg::CMD_MEM_WR, 32'h00001020, 32'hFFFFFFFF, 4'h5, 4'h1, 0, 1},
      '{pti_pkg::CMD_IO_RD, 32'h00001020, 32'h00000000, 4'h0, 4'h2, 0, 1},
      '{pti_pkg::CMD_MEM_WR, 32'h00002010, 32'h11111111, 4'h0, 4'h1, 0, 0},
      '{pti_pkg::CMD_CFG_WR, 32'h00001000, 32'hCAFE0001, 4'h0, 4'h1, 0, 0},
      '{pti_pkg::CMD_CFG_WR, 32'h00001000, 32'h0BAD0002, 4'h0, 4'h1, 1, 1},
      '{4'hF, 32'h00001010, 32'h22222222, 4'h0, 4'h1, 0, 0},
      '{pti_pkg::CMD_MEM_RD, 32'h00001010, 32'h00000000, 4'h0, 4'h1, 0, 1},
      '{pti_pkg::CMD_CFG_RD, 32'h00001000, 32'h00000000, 4'h0, 4'h1, 1, 1}};
      // reset taken at time zero, held for 16 cycles
      resetn <= 1'b0;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      // table rows: claim or refusal, data and write counts
      foreach (rows[i]) begin
         run(rows[i]);
         `CHK("done", rows[i].ok, got_done)
         `CHK("abort", !rows[i].ok, got_abort)
         exp_w = (rows[i].ok && rows[i].cmd[0]) ? rows[i].len : 0;
         `CHK("writes", exp_w, wr_seen)
      end
      `CHK("cfg_word", 32'h0BAD0002, cfg_word)
      // long burst must be cut short by the target
      run('{pti_pkg::CMD_MEM_WR, 32'h00001000, 32'h33333333, 0, 4'hF, 0, 1});
      `CHK("burst", int'(pti_pkg::BURST_MAX) - 1, wr_seen)
      `CHK("burst_done", 1'b1, got_done)
      // interrupt raised and dropped; four flops deep end to end
      irq_req <= 1'b1;
      repeat (5) @(posedge core_clk);
      `CHK("inta", 1'b0, bus.inta_n)
      `CHK("irq", 1'b1, irq)
      irq_req <= 1'b0;
      repeat (5) @(posedge core_clk);
      `CHK("irq_off", 1'b1, bus.inta_n)
      `CHK("irq_off_m", 1'b0, irq)
      // reset in mid transfer releases the bus
      cur <= rows[4];
      req <= 1'b1;
      @(posedge core_clk);
      req <= 1'b0;
      repeat (3) @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK("ctl_oe", 1'b1, bus.ctl_oe_n)
      `CHK("ad_oe", 1'b1, bus.t_ad_oe_n)
      `CHK("busy", 1'b0, busy)
      resetn <= 1'b1;
      run(rows[0]);
      `CHK("done_rst", 1'b1, got_done)
      end_of_test();
   end
endmodule : pci_target_bus_interface_bench

// [test/pti_target_asserts.sv]
`timescale 1ns/1ps
// watches the shared bus lines between the two ends
module pti_target_asserts #(
   parameter logic [31:0] BASE = pti_pkg::BASE_RST
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // bus lines
   input wire logic [31:0] ad,
   input wire logic [3:0] cbe_n,
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic idsel,
   input wire logic par,
   input wire logic trdy_n,
   input wire logic devsel_n,
   input wire logic stop_n,
   // drive enables
   input wire logic m_ad_oe_n,
   input wire logic t_ad_oe_n,
   input wire logic t_par_oe_n,
   input wire logic ctl_oe_n
);
   logic idle_r; // bus idle on the last edge
   logic [3:0] cmd_r; // command of the running access
   logic [3:0] beats_r; // completed beats, wraps only if never stopped
   logic addr_ph; // first frame-low cycle after idle
   logic impl; // command the target claims
   assign addr_ph = !frame_n && idle_r;
   assign impl = cbe_n[3:1] inside {3'h1, 3'h3}
      || (cbe_n[3:1] == 3'h5 && idsel);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // idle seen when neither frame nor initiator ready is low
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         idle_r <= 1'b1;
      end else begin
         idle_r <= frame_n && irdy_n;
      end
   end
   // command kept from the address phase
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmd_r <= 4'h0;
      end else if (addr_ph) begin
         cmd_r <= cbe_n;
      end
   end
   // beats restart at each address phase
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         beats_r <= 4'h0;
      end else if (addr_ph) begin
         beats_r <= 4'h0;
      end else if (!irdy_n && !trdy_n) begin
         beats_r <= beats_r + 4'h1;
      end
   end
   trdy_claimed_a: assert property (!trdy_n |-> !devsel_n)
      else $error("target ready without device select");
   stop_claimed_a: assert property (!stop_n |-> !devsel_n)
      else $error("stop without device select");
   burst_limit_a: assert property (beats_r <= pti_pkg::BURST_MAX)
      else $error("burst ran past the disconnect point");
   ad_one_drv_a: assert property (!(!m_ad_oe_n && !t_ad_oe_n))
      else $error("both ends drive address/data");
   rd_data_drv_a: assert property (
      !trdy_n && !cmd_r[0] |-> !t_ad_oe_n)
      else $error("read ready without data driven");
   rd_parity_a: assert property (
      !trdy_n && !irdy_n && !cmd_r[0]
      |=> !t_par_oe_n && par == ^{$past(ad), $past(cbe_n)})
      else $error("read parity wrong or late");
   claim_time_a: assert property (
      addr_ph && cbe_n[3:1] inside {3'h1, 3'h3} && ad[31:8] == BASE[31:8]
      |-> ##2 !devsel_n)
      else $error("own access not claimed in time");
   refuse_cmd_a: assert property (addr_ph && !impl |=> devsel_n [*3])
      else $error("foreign command claimed");
   hold_sel_a: assert property (
      !devsel_n && !irdy_n && trdy_n && stop_n |=> !devsel_n)
      else $error("device select dropped in a wait cycle");
   addr_par_a: assert property (
      addr_ph |=> par == ^{$past(ad), $past(cbe_n)})
      else $error("address parity wrong or late");
   reset_quiet_a: assert property (disable iff (1'b0)
      !resetn_i |-> ctl_oe_n && t_ad_oe_n && t_par_oe_n)
      else $error("target drives bus in reset");
endmodule : pti_target_asserts
